// [src/mfs_pkg.sv]
// Purpose: Constants for the motor fault and status register bank
// Assumes: Word offsets as seen on the device register interface
// Notes: All words are read-only status
package mfs_pkg;
  localparam logic [7:0] OFS_FAULT = 8'hE2;
  localparam logic [7:0] OFS_ALGO = 8'hE4;
  localparam logic [7:0] OFS_PARAMS = 8'hE6;
  localparam logic [7:0] OFS_EXTRACT = 8'hE8;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam int BIT_SUMMARY = 31;
  localparam int BIT_POS_FREQ = 29;
  localparam int BIT_POS_T1 = 28;
  localparam int BIT_POS_T2 = 27;
  localparam int BIT_BUS_ILIM = 26;
  localparam int BIT_EXT_RL = 25;
  localparam int BIT_EXT_BEMF = 24;
  localparam int BIT_ABNORMAL_SPEED_LOCK = 23;
  localparam int BIT_ABNORMAL_BACKEMF_LOCK = 22;
  localparam int BIT_ABSENT = 21;
  localparam int BIT_ANY_LOCK = 20;
  localparam int BIT_LOCK_ILIM = 19;
  localparam int BIT_HW_ILIM = 18;
  localparam int BIT_SUPPLY_LOW = 17;
  localparam int BIT_SUPPLY_HIGH = 16;
  localparam int BIT_SPEED_SAT = 15;
  localparam int BIT_CURR_SAT = 14;
  localparam int VMAG_LSB = 16;
  localparam int VMAG_W = 16;
  localparam int VMAG_FULL_SCALE = 32767;
  localparam int VMAG_PERCENT = 100;
  // Masks of the implemented bits; everything else reads zero
  localparam logic [31:0] MASK_PARAMS = 32'hFFFF_FF00;
  localparam logic [31:0] MASK_EXTRACT = 32'hFF00_0000;
endpackage

// [src/mfs_status_bank.sv]
// Purpose: Read-only controller fault and system status words
// Assumes: Detector and status inputs synchronous to sys_clk_i
// Notes: Read data is registered, one cycle after the read strobe
`timescale 1ns/1ns
module mfs_status_bank (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic position_detect_frequency_error_i,
  input wire logic position_detect_timing_one_error_i,
  input wire logic position_detect_timing_two_error_i,
  input wire logic bus_current_limit_i,
  input wire logic extraction_rl_error_i,
  input wire logic extraction_backemf_error_i,
  input wire logic abnormal_speed_lock_i,
  input wire logic abnormal_backemf_lock_i,
  input wire logic motor_absent_flag_i,
  input wire logic lock_current_limit_flag_i,
  input wire logic hardware_lock_current_flag_i,
  input wire logic motor_supply_low_flag_i,
  input wire logic motor_supply_high_flag_i,
  input wire logic speed_regulator_clipped_i,
  input wire logic current_regulator_clipped_i,
  input wire logic [15:0] output_voltage_magnitude_i,
  input wire logic [31:0] motor_parameter_results_i,
  input wire logic [31:0] extraction_status_word_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic controller_fault_o
);
  // Detector levels gathered in flag order, highest fault bit first
  logic [14:0] detect_vec;
  logic [14:0] flag_reg;
  logic lock_next;
  logic lock_reg;
  logic summary_next;
  logic summary_reg;
  logic [31:0] fault_word;
  logic [31:0] algo_next;
  logic [31:0] algo_reg;
  logic [31:0] params_next;
  logic [31:0] params_reg;
  logic [31:0] extract_next;
  logic [31:0] extract_reg;
  logic [3:0] sel_vec;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic unused_wr;

  // Read response sequencer
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } mfs_rd_state_t;

  mfs_rd_state_t rd_state_reg;
  mfs_rd_state_t rd_state_next;

  // Position detect faults and bus current limit
  assign detect_vec[14] = position_detect_frequency_error_i;
  assign detect_vec[13] = position_detect_timing_one_error_i;
  assign detect_vec[12] = position_detect_timing_two_error_i;
  assign detect_vec[11] = bus_current_limit_i;

  // Parameter extraction faults
  assign detect_vec[10] = extraction_rl_error_i;
  assign detect_vec[9] = extraction_backemf_error_i;

  // Lock detection types
  assign detect_vec[8] = abnormal_speed_lock_i;
  assign detect_vec[7] = abnormal_backemf_lock_i;
  assign detect_vec[6] = motor_absent_flag_i;
  assign detect_vec[5] = lock_current_limit_flag_i;
  assign detect_vec[4] = hardware_lock_current_flag_i;

  // Supply and regulator loop faults
  assign detect_vec[3] = motor_supply_low_flag_i;
  assign detect_vec[2] = motor_supply_high_flag_i;
  assign detect_vec[1] = speed_regulator_clipped_i;
  assign detect_vec[0] = current_regulator_clipped_i;

  // One flop per detector, so each flag follows its source
  for (genvar g = 0; g < 15; g++) begin : gen_flag
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        flag_reg[g] <= 1'b0;
      end else begin
        flag_reg[g] <= detect_vec[g];
      end
    end
  end

  // Lock summary covers every lock detection type
  always_comb begin
    lock_next = abnormal_speed_lock_i;
    lock_next = lock_next | abnormal_backemf_lock_i;
    lock_next = lock_next | motor_absent_flag_i;
    lock_next = lock_next | lock_current_limit_flag_i;
    lock_next = lock_next | hardware_lock_current_flag_i;
  end

  // Lock types are a subset of the detectors, so bit 20 is inside the summary
  always_comb begin
    summary_next = |detect_vec;
  end

  // Registered with the flags so the summaries never lag them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= summary_next;
    end
  end

  // Reserved bits 30 and 13-0 stay zero
  always_comb begin
    fault_word = mfs_pkg::WORD_RESET;
    fault_word[mfs_pkg::BIT_SUMMARY] = summary_reg;

    // Position detect and bus current limit
    fault_word[mfs_pkg::BIT_POS_FREQ] = flag_reg[14];
    fault_word[mfs_pkg::BIT_POS_T1] = flag_reg[13];
    fault_word[mfs_pkg::BIT_POS_T2] = flag_reg[12];
    fault_word[mfs_pkg::BIT_BUS_ILIM] = flag_reg[11];

    // Parameter extraction
    fault_word[mfs_pkg::BIT_EXT_RL] = flag_reg[10];
    fault_word[mfs_pkg::BIT_EXT_BEMF] = flag_reg[9];

    // Motor lock
    fault_word[mfs_pkg::BIT_ABNORMAL_SPEED_LOCK] = flag_reg[8];
    fault_word[mfs_pkg::BIT_ABNORMAL_BACKEMF_LOCK] = flag_reg[7];
    fault_word[mfs_pkg::BIT_ABSENT] = flag_reg[6];
    fault_word[mfs_pkg::BIT_ANY_LOCK] = lock_reg;
    fault_word[mfs_pkg::BIT_LOCK_ILIM] = flag_reg[5];
    fault_word[mfs_pkg::BIT_HW_ILIM] = flag_reg[4];

    // Supply and regulator loops
    fault_word[mfs_pkg::BIT_SUPPLY_LOW] = flag_reg[3];
    fault_word[mfs_pkg::BIT_SUPPLY_HIGH] = flag_reg[2];
    fault_word[mfs_pkg::BIT_SPEED_SAT] = flag_reg[1];
    fault_word[mfs_pkg::BIT_CURR_SAT] = flag_reg[0];
  end

  // Voltage magnitude in the upper half of the algorithm word
  always_comb begin
    algo_next = mfs_pkg::WORD_RESET;
    algo_next[mfs_pkg::VMAG_LSB +: mfs_pkg::VMAG_W] = output_voltage_magnitude_i;
  end

  // Reserved low byte of the parameter word masked off
  always_comb begin
    params_next = motor_parameter_results_i & mfs_pkg::MASK_PARAMS;
  end

  // Only the top byte of the extraction word is implemented
  always_comb begin
    extract_next = extraction_status_word_i & mfs_pkg::MASK_EXTRACT;
  end

  // Status words sampled each cycle from the live sources
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      algo_reg <= mfs_pkg::WORD_RESET;
    end else begin
      algo_reg <= algo_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      params_reg <= mfs_pkg::WORD_RESET;
    end else begin
      params_reg <= params_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      extract_reg <= mfs_pkg::WORD_RESET;
    end else begin
      extract_reg <= extract_next;
    end
  end

  // Exact offset match, one select per word
  assign sel_vec[3] = (reg_addr_i == mfs_pkg::OFS_FAULT);
  assign sel_vec[2] = (reg_addr_i == mfs_pkg::OFS_ALGO);
  assign sel_vec[1] = (reg_addr_i == mfs_pkg::OFS_PARAMS);
  assign sel_vec[0] = (reg_addr_i == mfs_pkg::OFS_EXTRACT);

  // No select means a reserved offset, which reads zero
  always_comb begin
    rdata_next = mfs_pkg::WORD_RESET;
    unique case (sel_vec)
      4'h8: begin
        rdata_next = fault_word;
      end
      4'h4: begin
        rdata_next = algo_reg;
      end
      4'h2: begin
        rdata_next = params_reg;
      end
      4'h1: begin
        rdata_next = extract_reg;
      end
      default: begin
        rdata_next = mfs_pkg::WORD_RESET;
      end
    endcase
  end

  // A strobe in the response cycle starts another response
  always_comb begin
    rd_state_next = RD_IDLE;
    unique case (rd_state_reg)
      RD_IDLE: begin
        if (reg_rd_i) begin
          rd_state_next = RD_RESP;
        end
      end
      RD_RESP: begin
        if (reg_rd_i) begin
          rd_state_next = RD_RESP;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
  end

  // Response lasts exactly one cycle per strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state_reg <= RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  // Read data changes only on a strobe and holds until the next read
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= mfs_pkg::WORD_RESET;
    end else begin
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Writes reach no storage: every word is read-only
  assign unused_wr = reg_wr_i & (|reg_wdata_i);

  // Outputs
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = (rd_state_reg == RD_RESP);
  assign controller_fault_o = summary_reg;
endmodule

// [tb/mfs_status_bank_props.sv]
// Purpose: Port checks for the fault and status bank
// Assumes: Read data lands one edge after the read, two edges behind inputs
// Notes: Bound to every bank instance
`timescale 1ns/1ns
module mfs_status_bank_props (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic bus_current_limit_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] output_voltage_magnitude_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] a1;
  always_ff @(posedge sys_clk_i) a1 <= reg_addr_i;
  wire f = reg_rvalid_o && a1 == 8'hE2;
  wire s = reg_rvalid_o && a1 == 8'hE4;
  property p_rv; reg_rvalid_o == $past(reg_rd_i); endproperty
  a_rv: assert property (p_rv) else $error("read valid late");
  property p_hold; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_sum; f |-> reg_rdata_o[31] == |reg_rdata_o[30:0]; endproperty
  a_sum: assert property (p_sum) else $error("summary bit");
  property p_lck; f |-> reg_rdata_o[20] == |{reg_rdata_o[23:21], reg_rdata_o[19:18]}; endproperty
  a_lck: assert property (p_lck) else $error("lock bit");
  property p_rsv; f |-> !reg_rdata_o[30] && reg_rdata_o[13:0] == 14'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_bus; f |-> reg_rdata_o[26] == $past(bus_current_limit_i, 2); endproperty
  a_bus: assert property (p_bus) else $error("bus limit bit");
  property p_vm; s |-> reg_rdata_o == {$past(output_voltage_magnitude_i, 2), 16'h0}; endproperty
  a_vm: assert property (p_vm) else $error("voltage field");
  property p_map; reg_rvalid_o && !(a1 inside {8'hE2, 8'hE4, 8'hE6, 8'hE8}) |-> reg_rdata_o == 32'h0; endproperty
  a_map: assert property (p_map) else $error("unmapped read");
  c_flt: cover property (f && reg_rdata_o[31]);
  c_vm: cover property (s);
  c_map: cover property (reg_rvalid_o && a1 == 8'hE0);
endmodule
bind mfs_status_bank mfs_status_bank_props mfs_status_bank_props_inst (.*);

// [tb/mfs_status_bank_tb_top.sv]
// Purpose: Self-checking bench for the fault and status bank
// Assumes: One read at a time, inputs change at rising edges
// Notes: Expected words are built from the bit map
`timescale 1ns/1ns
module mfs_status_bank_tb_top;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, rv, cf;
  logic [14:0] fl = 15'h0;
  logic [15:0] vm = 16'h0;
  logic [31:0] pr = 32'h0, ex = 32'h0, wd = 32'h0, q, rdat;
  logic [7:0] ad = 8'h0;
  int n_fail = 0, n_checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  mfs_status_bank mfs_status_bank_inst (.sys_clk_i, .rst_i, .position_detect_frequency_error_i(fl[14]),
    .position_detect_timing_one_error_i(fl[13]), .position_detect_timing_two_error_i(fl[12]),
    .bus_current_limit_i(fl[11]), .extraction_rl_error_i(fl[10]), .extraction_backemf_error_i(fl[9]),
    .abnormal_speed_lock_i(fl[8]), .abnormal_backemf_lock_i(fl[7]), .motor_absent_flag_i(fl[6]),
    .lock_current_limit_flag_i(fl[5]), .hardware_lock_current_flag_i(fl[4]), .motor_supply_low_flag_i(fl[3]),
    .motor_supply_high_flag_i(fl[2]), .speed_regulator_clipped_i(fl[1]), .current_regulator_clipped_i(fl[0]),
    .output_voltage_magnitude_i(vm), .motor_parameter_results_i(pr), .extraction_status_word_i(ex),
    .reg_addr_i(ad), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .controller_fault_o(cf));
  function automatic logic [31:0] fw(logic [14:0] f);
    fw = {|f, 1'b0, f[14:6], |f[8:4], f[5:0], 14'h0};
  endfunction
  task end_sim;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdw(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge sys_clk_i) {ad, rd} <= {a, 1'b1};
    @(posedge sys_clk_i) rd <= 1'b0;
    #1;
    for (k = 0; k < 4 && rv !== 1'b1; k++) @(posedge sys_clk_i) #1;
    if (k == 4) begin
      n_fail++;
      end_sim;
    end
    d = rdat;
  endtask
  task t_rst;
    foreach (pr[i]) if (i < 4) begin
      rdw(8'hE2 + 8'(2 * i), q);
      chk("reset word", q, 32'h0);
    end
    $display("reset test done");
  endtask
  task t_flags;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk_i) fl <= (i == 15) ? 15'h7FFF : 15'h1 << i;
      rdw(8'hE2, q);
      chk("fault word", q, fw((i == 15) ? 15'h7FFF : 15'h1 << i));
      chk("fault out", {31'h0, cf}, 32'h1);
    end
    @(posedge sys_clk_i) fl <= 15'h0;
    rdw(8'hE2, q);
    chk("fault clear", q, 32'h0);
    chk("fault out clear", {31'h0, cf}, 32'h0);
    $display("flag test done");
  endtask
  task t_stat;
    @(posedge sys_clk_i) {vm, pr, ex} <= {16'h7FFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
    rdw(8'hE4, q);
    chk("voltage", q, 32'h7FFF0000);
    rdw(8'hE6, q);
    chk("params", q, 32'hFFFFFF00);
    rdw(8'hE8, q);
    chk("extract", q, 32'hFF000000);
    $display("status test done");
  endtask
  task t_ro;
    @(posedge sys_clk_i) {ad, wr, wd, vm} <= {8'hE4, 1'b1, 32'hFFFFFFFF, 16'h1234};
    @(posedge sys_clk_i) wr <= 1'b0;
    rdw(8'hE4, q);
    chk("write ignored", q, 32'h12340000);
    rdw(8'hE0, q);
    chk("unmapped", q, 32'h0);
    rdw(8'hE5, q);
    chk("odd offset", q, 32'h0);
    $display("read-only test done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_rst;
    t_flags;
    t_stat;
    t_ro;
    end_sim;
  end
endmodule
